// ==== rtl/als_pkg.sv ====
// constants and types for the light sensor i2c target and conversion timer
package als_pkg;

  // i2c target address, 7-bit form of write byte 26h / read byte 27h
  localparam logic [6:0] ALS_DEV_ADDR = 7'h13;

  // register offsets
  localparam logic [7:0] ALS_PARAM_OFS = 8'h84;
  localparam logic [7:0] ALS_RES_HI_OFS = 8'h85;
  localparam logic [7:0] ALS_RES_LO_OFS = 8'h86;

  // parameter register layout and reset
  localparam int ALS_PARAM_CONT_BIT = 7;
  localparam int ALS_PARAM_AVG_LSB = 0;
  localparam int ALS_PARAM_AVG_W = 3;
  localparam logic [7:0] ALS_PARAM_RST = 8'h00;
  localparam logic [7:0] ALS_UNMAPPED_DATA = 8'h00;

  // averaging: count is 2**exponent, at most 128
  localparam int ALS_AVG_MAX = 128;
  localparam int ALS_CNT_W = $clog2(ALS_AVG_MAX + 1);
  localparam int ALS_ACC_W = 16 + $clog2(ALS_AVG_MAX);

  // timing
  localparam int ALS_MCLK_MHZ = 100;
  localparam int ALS_FRAME_MS = 100;
  localparam int ALS_CONV_US = 300;
  localparam int ALS_FRAME_CYC = ALS_FRAME_MS * 1000 * ALS_MCLK_MHZ;
  localparam int ALS_CONV_CYC = ALS_CONV_US * ALS_MCLK_MHZ;

  // i2c byte bit counter: 0..7 data, 8 acknowledge
  localparam logic [3:0] ALS_BIT_LAST = 4'h7;
  localparam logic [3:0] ALS_BIT_ACK = 4'h8;

  typedef enum logic [2:0] {
    ALS_ST_ADDR = 3'b000,
    ALS_ST_PTR = 3'b001,
    ALS_ST_WR = 3'b010,
    ALS_ST_RD = 3'b011,
    ALS_ST_SKIP = 3'b100
  } als_bus_e;

  typedef enum logic [0:0] {
    ALS_M_CONV = 1'b0,
    ALS_M_WAIT = 1'b1
  } als_meas_e;

endpackage : als_pkg

// ==== rtl/als_i2c_target.sv ====
// light sensor i2c register target with ambient light conversion timing
`timescale 1ns/100ps

// Functional notes
// RULE1: host selects a register by writing only the pointer byte to address 26h.
// RULE2: a read to address 27h returns the register the last pointer write selected.
// RULE3: pointer write and read may be split by stop plus start or repeated start.
// RULE4: every register byte read advances the internal pointer by one.
// RULE5: light result high byte sits at 85h, low byte at 86h.
// RULE6: parameter register bit 7 low is standard mode, high is continuous mode.
// RULE7: standard mode runs each measurement cycle in a fixed 100 ms frame.
// RULE8: each single conversion takes about 300 us in either mode.
// RULE9: averaging count is programmable up to 128 single conversions.
// RULE10: final result is the arithmetic mean of the selected conversions.
// RULE11: standard mode publishes the mean only at the end of the frame.
// RULE12: continuous mode starts each conversion right after the previous one.
// RULE13: continuous mode updates the result when the last conversion of the set ends.
// RULE14: high and low result bytes update together for a consistent 16-bit read.
module als_i2c_target #(
  parameter int FRAME_CYC = als_pkg::ALS_FRAME_CYC,
  parameter int CONV_CYC = als_pkg::ALS_CONV_CYC
) (
  // system
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  // i2c link, scl clocks the bit engine
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // converter sample, mclk domain
  input wire logic [15:0] als_raw,
  // status
  output logic [15:0] als_result,
  output logic result_stb,
  output logic bus_busy
);
  import als_pkg::*;

  localparam int FW = $clog2(FRAME_CYC + 1);
  localparam int CW = $clog2(CONV_CYC + 1);
  localparam logic [FW-1:0] FRAME_LAST = FW'(FRAME_CYC - 1);
  localparam logic [CW-1:0] CONV_LAST = CW'(CONV_CYC - 1);

  // register read decode, used by the bit engine
  function automatic logic [7:0] reg_read(input logic [7:0] ptr, input logic [7:0] param,
                                          input logic [15:0] res);
    logic [7:0] d;
    d = ALS_UNMAPPED_DATA;
    if (ptr == ALS_PARAM_OFS) begin
      d = param;
    end else if (ptr == ALS_RES_HI_OFS) begin // see RULE5
      d = res[15:8];
    end else if (ptr == ALS_RES_LO_OFS) begin // see RULE5
      d = res[7:0];
    end
    return d;
  endfunction : reg_read

  // ---------------- mclk: pin synchronisers, start/stop, bus view ----------------
  logic scl_m1_ff, scl_m2_ff, sda_m1_ff, sda_m2_ff, sda_m3_ff;
  logic busy_ff, clr_ff;
  logic nxt_busy, nxt_clr;
  logic start_det, stop_det;
  logic [15:0] view_ff, nxt_view;
  logic [15:0] result_ff;
  logic cont_ff, nxt_cont;
  logic [ALS_PARAM_AVG_W-1:0] avg_ff, nxt_avg;
  logic [7:0] param_ff;
  logic restart_ff, nxt_restart;

  always_comb begin
    start_det = scl_m2_ff & sda_m3_ff & ~sda_m2_ff;
    stop_det = scl_m2_ff & ~sda_m3_ff & sda_m2_ff;
    nxt_busy = busy_ff;
    if (start_det) begin
      nxt_busy = 1'b1;
    end else if (stop_det) begin
      nxt_busy = 1'b0;
    end
    // start, repeated start and stop all bring the bit engine back to address phase
    nxt_clr = start_det | stop_det; // see RULE3
    nxt_view = view_ff;
    nxt_cont = cont_ff;
    nxt_avg = avg_ff;
    // words only cross while the bus is quiet, so neither side sees them move
    if (!busy_ff) begin
      nxt_view = result_ff; // see RULE14
      nxt_cont = param_ff[ALS_PARAM_CONT_BIT]; // see RULE6
      nxt_avg = param_ff[ALS_PARAM_AVG_LSB +: ALS_PARAM_AVG_W]; // see RULE9
    end
    // a new mode or count mid-set would mix two averaging sets, so start over
    nxt_restart = (nxt_cont != cont_ff) | (nxt_avg != avg_ff); // see RULE10
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      scl_m1_ff <= 1'b1;
      scl_m2_ff <= 1'b1;
      sda_m1_ff <= 1'b1;
      sda_m2_ff <= 1'b1;
      sda_m3_ff <= 1'b1;
      busy_ff <= 1'b0;
      clr_ff <= 1'b0;
      view_ff <= 16'h0000;
      cont_ff <= 1'b0;
      avg_ff <= '0;
      restart_ff <= 1'b0;
    end else if (ce) begin
      scl_m1_ff <= scl;
      scl_m2_ff <= scl_m1_ff;
      sda_m1_ff <= sda_in;
      sda_m2_ff <= sda_m1_ff;
      sda_m3_ff <= sda_m2_ff;
      busy_ff <= nxt_busy;
      clr_ff <= nxt_clr;
      view_ff <= nxt_view;
      cont_ff <= nxt_cont;
      avg_ff <= nxt_avg;
      restart_ff <= nxt_restart;
    end
  end

  assign bus_busy = busy_ff;

  // ---------------- scl: bit engine ----------------
  // cleared asynchronously by a start or stop seen on mclk; scl is high then,
  // so the release lands long before the next scl edge
  logic eng_rst;
  assign eng_rst = rst | clr_ff;

  als_bus_e st_ff, nxt_st;
  logic [3:0] cnt_ff, nxt_cnt;
  logic [7:0] sh_ff, nxt_sh;
  logic ack_ff, nxt_ack;
  logic [7:0] ptr_ff, nxt_ptr;
  logic [7:0] nxt_param;
  logic [7:0] byte_in;

  always_comb begin
    nxt_st = st_ff;
    nxt_cnt = cnt_ff;
    nxt_sh = sh_ff;
    nxt_ack = ack_ff;
    nxt_ptr = ptr_ff;
    nxt_param = param_ff;
    byte_in = {sh_ff[6:0], sda_in};
    if (cnt_ff != ALS_BIT_ACK) begin
      nxt_sh = byte_in;
      nxt_cnt = cnt_ff + 4'h1;
      if (cnt_ff == ALS_BIT_LAST) begin
        unique case (st_ff)
          ALS_ST_ADDR: nxt_ack = (byte_in[7:1] == ALS_DEV_ADDR);
          ALS_ST_PTR: nxt_ack = 1'b1;
          ALS_ST_WR: nxt_ack = 1'b1;
          ALS_ST_RD: nxt_ack = 1'b0;
          ALS_ST_SKIP: nxt_ack = 1'b0;
          default: nxt_ack = 1'b0;
        endcase
      end
    end else begin
      nxt_cnt = 4'h0;
      nxt_ack = 1'b0;
      unique case (st_ff)
        ALS_ST_ADDR: begin
          if (!ack_ff) begin
            nxt_st = ALS_ST_SKIP;
          end else if (sh_ff[0]) begin
            nxt_st = ALS_ST_RD; // see RULE2
          end else begin
            nxt_st = ALS_ST_PTR; // see RULE1
          end
        end
        ALS_ST_PTR: begin
          // first written byte is the register pointer, data bytes optional
          nxt_ptr = sh_ff; // see RULE1
          nxt_st = ALS_ST_WR;
        end
        ALS_ST_WR: begin
          // data for other registers is dropped, the pointer still moves
          if (ptr_ff == ALS_PARAM_OFS) begin
            nxt_param = sh_ff; // see RULE6
          end
          nxt_ptr = ptr_ff + 8'h01;
        end
        ALS_ST_RD: begin
          nxt_ptr = ptr_ff + 8'h01; // see RULE4
          // host nack ends the read; we let go of sda until the next start
          if (sda_in) begin
            nxt_st = ALS_ST_SKIP;
          end
        end
        ALS_ST_SKIP: nxt_st = ALS_ST_SKIP;
        default: nxt_st = ALS_ST_SKIP;
      endcase
    end
  end

  always_ff @(posedge scl or posedge eng_rst) begin
    if (eng_rst) begin
      st_ff <= ALS_ST_ADDR;
      cnt_ff <= 4'h0;
      sh_ff <= 8'h00;
      ack_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      sh_ff <= nxt_sh;
      ack_ff <= nxt_ack;
    end
  end

  // pointer and parameter survive start/stop, only the system reset clears them
  always_ff @(posedge scl or posedge rst) begin
    if (rst) begin
      ptr_ff <= 8'h00;
      param_ff <= ALS_PARAM_RST;
    end else begin
      ptr_ff <= nxt_ptr;
      param_ff <= nxt_param;
    end
  end

  // sda drive changes on the falling scl edge, open drain: only ever pulls low
  logic oe_ff, nxt_oe;
  logic [7:0] rd_byte;

  always_comb begin
    rd_byte = reg_read(ptr_ff, param_ff, view_ff); // see RULE2
    nxt_oe = 1'b0;
    if (cnt_ff == ALS_BIT_ACK) begin
      nxt_oe = ack_ff;
    end else if (st_ff == ALS_ST_RD) begin
      nxt_oe = ~rd_byte[3'(ALS_BIT_LAST - cnt_ff)];
    end
  end

  always_ff @(negedge scl or posedge eng_rst) begin
    if (eng_rst) begin
      oe_ff <= 1'b0;
    end else begin
      oe_ff <= nxt_oe;
    end
  end

  // never driven high, the pull-up supplies the one
  assign sda_out = 1'b0;
  assign sda_oe = oe_ff;

  // ---------------- mclk: conversion timing and averaging ----------------
  als_meas_e ms_ff, nxt_ms;
  logic [FW-1:0] frame_ff, nxt_frame;
  logic [CW-1:0] conv_ff, nxt_conv;
  logic [ALS_CNT_W-1:0] n_ff, nxt_n;
  logic [ALS_CNT_W-1:0] target;
  logic [ALS_ACC_W-1:0] acc_ff, nxt_acc;
  logic [ALS_ACC_W-1:0] sum;
  logic [15:0] nxt_result;
  logic stb_ff, nxt_stb;
  logic frame_end;

  always_comb begin
    target = ALS_CNT_W'(1) << avg_ff; // see RULE9
    sum = acc_ff + ALS_ACC_W'(als_raw);
    frame_end = (frame_ff == FRAME_LAST);
    nxt_frame = frame_end ? '0 : frame_ff + FW'(1); // see RULE7
    nxt_ms = ms_ff;
    nxt_conv = conv_ff;
    nxt_n = n_ff;
    nxt_acc = acc_ff;
    nxt_result = result_ff;
    nxt_stb = 1'b0;
    if (restart_ff) begin
      // stale partial set is dropped, the frame counter keeps its phase
      nxt_ms = ALS_M_CONV; // see RULE10
      nxt_conv = '0;
      nxt_n = '0;
      nxt_acc = '0;
    end else if (!cont_ff && frame_end) begin
      // result only leaves at the frame boundary, however short the set was
      if (ms_ff == ALS_M_WAIT) begin
        nxt_result = 16'(acc_ff >> avg_ff); // see RULE11
        nxt_stb = 1'b1;
      end
      nxt_ms = ALS_M_CONV; // see RULE7
      nxt_conv = '0;
      nxt_n = '0;
      nxt_acc = '0;
    end else if (cont_ff && ms_ff == ALS_M_WAIT) begin
      // a parked set has no frame to wait for in continuous mode
      nxt_ms = ALS_M_CONV; // see RULE12
    end else if (ms_ff == ALS_M_CONV) begin
      if (conv_ff == CONV_LAST) begin // see RULE8
        nxt_conv = '0;
        if (n_ff >= target - ALS_CNT_W'(1)) begin
          if (cont_ff) begin
            // mean is a shift because the count is a power of two
            nxt_result = 16'(sum >> avg_ff); // see RULE10
            nxt_stb = 1'b1; // see RULE13
            nxt_n = '0;
            nxt_acc = '0;
          end else begin
            nxt_acc = sum;
            nxt_ms = ALS_M_WAIT;
          end
        end else begin
          // back to back: next conversion starts on the following cycle
          nxt_acc = sum; // see RULE12
          nxt_n = n_ff + ALS_CNT_W'(1);
        end
      end else begin
        nxt_conv = conv_ff + CW'(1);
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ms_ff <= ALS_M_CONV;
      frame_ff <= '0;
      conv_ff <= '0;
      n_ff <= '0;
      acc_ff <= '0;
      result_ff <= 16'h0000;
      stb_ff <= 1'b0;
    end else if (ce) begin
      ms_ff <= nxt_ms;
      frame_ff <= nxt_frame;
      conv_ff <= nxt_conv;
      n_ff <= nxt_n;
      acc_ff <= nxt_acc;
      result_ff <= nxt_result; // see RULE14
      stb_ff <= nxt_stb;
    end
  end

  assign als_result = result_ff;
  assign result_stb = stb_ff;

endmodule : als_i2c_target

// ==== verif/als_i2c_target_asserts.sv ====
// concurrent checks on the light sensor i2c target ports
`timescale 1ns/100ps
module als_i2c_target_chk #(
  parameter int FRAME_CYC = 2000,
  parameter int CONV_CYC = 10
) (
  // system
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  // i2c link
  input wire logic scl,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  // converter and status
  input wire logic [15:0] als_raw,
  input wire logic [15:0] als_result,
  input wire logic result_stb,
  input wire logic bus_busy
);
  int gap_ff;
  int nxt_gap;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // cycles since last publish; frozen with ce so the bound stays honest
  always_comb begin
    nxt_gap = result_stb ? 0 : (ce ? gap_ff + 1 : gap_ff);
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      gap_ff <= 0;
    end else begin
      gap_ff <= nxt_gap;
    end
  end
  a_stb_single: assert property (result_stb |=> !result_stb)
    else $error("result strobe longer than one cycle");
  a_result_tied: assert property ($changed(als_result) |-> result_stb)
    else $error("result moved without strobe");
  a_gap_bound: assert property (gap_ff < 3 * FRAME_CYC)
    else $error("no result published for three frames");
  a_open_drain: assert property (sda_out == 1'b0)
    else $error("data line driven high");
  a_idle_quiet: assert property (!bus_busy |-> !sda_oe)
    else $error("data line pulled while bus idle");
  a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl)
    else $error("data drive changed while clock high");
  a_start_busy: assert property (scl && $past(scl) && $fell(sda_in) |-> ##[1:6] bus_busy)
    else $error("start not followed by busy");
  a_stop_idle: assert property (scl && $past(scl) && $rose(sda_in) |-> ##[1:6] !bus_busy)
    else $error("stop not followed by idle");
  cover property (result_stb && gap_ff == 2 * CONV_CYC - 1);
  cover property ($rose(bus_busy));
  cover property ($rose(sda_oe) && bus_busy);
endmodule : als_i2c_target_chk

// ==== verif/als_host_model.sv ====
// i2c host model driving clock and data toward the light sensor target
`timescale 1ns/100ps
module als_host_model (
  // i2c wire, released data floats to the pull-up
  output logic scl,
  output logic sda_oe,
  input wire logic sda
);
  initial begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end
  // start or repeated start; clock held high 600 ns after data falls, before first fall
  task automatic start();
    sda_oe = 1'b0;
    #16 scl = 1'b1;
    #100 sda_oe = 1'b1;
    #600 scl = 1'b0;
  endtask : start
  task automatic stop();
    sda_oe = 1'b1;
    #16 scl = 1'b1;
    #100 sda_oe = 1'b0;
    #200;
  endtask : stop
  // eight bits plus ninth; a read sends 8'hff so the line stays free
  task automatic xfer(input logic [7:0] w, input logic a_in, output logic [7:0] r,
                      output logic a);
    logic [8:0] s;
    logic [8:0] q;
    s = {w, a_in};
    for (int i = 8; i >= 0; i--) begin
      // data moves just after the fall, so mclk never sees it move with scl high
      #2 sda_oe = !s[i];
      #14 scl = 1'b1;
      #8 q[i] = sda;
      #8 scl = 1'b0;
    end
    r = q[8:1];
    a = !q[0];
  endtask : xfer
endmodule : als_host_model

// ==== verif/als_i2c_target_bench.sv ====
// self-checking bench for the light sensor i2c target
`timescale 1ns/100ps
module als_i2c_target_bench;
  import als_pkg::*;
  localparam int FRAME_CYC = 2000;
  localparam int CONV_CYC = 10;
  logic mclk, rst, ce, scl, sda_in, sda_out, sda_oe, h_oe, result_stb, bus_busy;
  logic [15:0] als_raw;
  logic [15:0] als_result;
  int n_fail, num_checks, cyc;
  assign sda_in = !(h_oe || sda_oe);
  als_i2c_target #(.FRAME_CYC(FRAME_CYC), .CONV_CYC(CONV_CYC)) dut (
    .mclk(mclk), .rst(rst), .ce(ce), .scl(scl), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .als_raw(als_raw), .als_result(als_result),
    .result_stb(result_stb), .bus_busy(bus_busy));
  als_host_model host (.scl(scl), .sda_oe(h_oe), .sda(sda_in));
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: expected %h got %h", $time, exp, got);
    end
  endtask : chk
  task automatic wait_stb(output int n);
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (result_stb !== 1'b1 && n < 5000);
  endtask : wait_stb
  task automatic put(input logic [7:0] b);
    logic [7:0] r;
    logic a;
    host.xfer(b, 1'b1, r, a);
    chk(16'h1, {15'h0, a});
  endtask : put
  task automatic wr_param(input logic [7:0] v);
    host.start();
    put({ALS_DEV_ADDR, 1'b0});
    put(ALS_PARAM_OFS);
    put(v);
    host.stop();
  endtask : wr_param
  // pointer write, then a two-byte read with host ack then nack
  task automatic rd2(input logic [7:0] ptr, input logic rep, output logic [15:0] v);
    logic a;
    host.start();
    put({ALS_DEV_ADDR, 1'b0});
    put(ptr);
    if (!rep) host.stop();
    host.start();
    put({ALS_DEV_ADDR, 1'b1});
    host.xfer(8'hff, 1'b0, v[15:8], a);
    host.xfer(8'hff, 1'b1, v[7:0], a);
    host.stop();
  endtask : rd2
  task automatic t_nack();
    logic [7:0] r;
    logic a;
    host.start();
    host.xfer(8'ha0, 1'b1, r, a);
    host.stop();
    chk(16'h0, {15'h0, a});
  endtask : t_nack
  task automatic t_std();
    int n;
    als_raw = 16'h4a5c;
    for (int e = 0; e < 8; e += 7) begin
      wr_param(8'(e));
      wait_stb(n);
      wait_stb(n);
      wait_stb(n);
      chk(16'(FRAME_CYC), 16'(n));
      chk(16'h4a5c, als_result);
    end
  endtask : t_std
  // samples change mid-conversion so each lands on a known value
  task automatic t_cont();
    int n;
    logic [15:0] v;
    wr_param(8'h81);
    wait_stb(n);
    wait_stb(n);
    repeat (5) @(negedge mclk);
    als_raw = 16'h1000;
    repeat (10) @(negedge mclk);
    als_raw = 16'h2003;
    wait_stb(n);
    chk(16'd20, 16'(n + 15));
    chk(16'h1801, als_result);
    repeat (50) @(negedge mclk);
    rd2(ALS_RES_HI_OFS, 1'b0, v);
    chk(16'h2003, v);
    rd2(ALS_PARAM_OFS, 1'b1, v);
    chk(16'h8120, v);
  endtask : t_cont
  // ce low holds every mclk counter in the target, so the next publish slips by the frozen span
  task automatic t_freeze();
    int n;
    int k;
    k = 0;
    wait_stb(n);
    @(negedge mclk);
    ce = 1'b0;
    repeat (60) begin
      @(negedge mclk);
      if (result_stb === 1'b1) begin
        k++;
      end
    end
    ce = 1'b1;
    chk(16'h0, 16'(k));
    wait_stb(n);
    chk(16'(2 * CONV_CYC - 1), 16'(n));
  endtask : t_freeze
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    als_raw = 16'h0;
    repeat (16) @(posedge mclk);
    @(negedge mclk);
    rst = 1'b0;
    repeat (5) @(negedge mclk);
    t_nack();
    t_std();
    t_cont();
    t_freeze();
    complete_run();
  end
  // run ceiling well above the three frame waits per scenario
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_fail++;
      complete_run();
    end
  end
endmodule : als_i2c_target_bench
bind als_i2c_target als_i2c_target_chk #(.FRAME_CYC(FRAME_CYC), .CONV_CYC(CONV_CYC)) u_chk (
  .mclk(mclk), .rst(rst), .ce(ce), .scl(scl), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .als_raw(als_raw), .als_result(als_result),
  .result_stb(result_stb), .bus_busy(bus_busy));
